// file: design/pea_group.sv
// One 8-bit event group: sticky status bits with one pending level per source.
`include "pea_map.svh"
module pea_group
	import pea_pkg::*;
(
	input wire logic sys_clk, // Device clock.
	input wire logic sys_rst, // Asynchronous reset, active high.
	input wire logic clkEn, // Freezes all state while low.
	input wire logic [7:0] evt, // Qualified, unmasked event pulses.
	input wire logic [7:0] clr, // Bits to clear this cycle.
	input wire logic alertActive, // Alert line currently asserted.
	input wire logic keepRepeat, // Store repeats as pending.
	output logic [7:0] status // Sticky status bits.
);
	pea_grp_st_t st;
	pea_grp_st_t next_st;
	logic [7:0] repeatEvt;

	always_comb begin
		next_st = st;
		repeatEvt = evt & st.status;
		// A clear on a bit with a pending level consumes the pending level only.
		next_st.status = (st.status & ~(clr & ~st.pending)) | evt;
		next_st.pending = st.pending & ~clr;
		// Repeats are dropped unless keeping is on; a new event wins over a clear.
		if (alertActive && keepRepeat) begin
			next_st.pending = next_st.pending | repeatEvt;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else if (clkEn) begin
			st <= next_st;
		end
	end

	assign status = st.status;
endmodule

// file: design/pea_map.svh
// Register offsets, field positions, reset values and timing counts of the event aggregator.
`ifndef PEA_MAP_SVH
`define PEA_MAP_SVH

`define PEA_ADDR_W 8
`define PEA_PIN_W 11
`define PEA_OFF_STATUS 8'h00
`define PEA_OFF_MASK 8'h04
`define PEA_OFF_LINE 8'h08
`define PEA_OFF_RISE4 8'h0c
`define PEA_OFF_FALL4 8'h0d
`define PEA_OFF_CTRL 8'h0e
`define PEA_OFF_KEYDLY 8'h0f
`define PEA_OFF_AUX 8'h10
`define PEA_UNMAPPED_RD 8'hff
`define PEA_CTRL_POL 0
`define PEA_CTRL_CLRWR 1
`define PEA_CTRL_KEEP 2
`define PEA_AUX_FSSEL 0
`define PEA_AUX_ADC0_ABOVE 1
`define PEA_AUX_ADC1_ABOVE 2
`define PEA_RST_MASK 8'h00
`define PEA_RST_EDGE 8'h00
`define PEA_RST_CTRL 3'h0
`define PEA_RST_KEYDLY 8'h08
`define PEA_RST_AUX 3'h1
`define PEA_G1_SUPPLY 6
`define PEA_G1_HOT 5
`define PEA_G1_PWROFF 4
`define PEA_G1_HELD 2
`define PEA_G1_KEY 1
`define PEA_G2_SHORT 6
`define PEA_G2_FIRST 5
`define PEA_G2_EXTRST 4
`define PEA_G2_WDOG 2
`define PEA_G2_FUSE 1
`define PEA_G3_BUS 7
`define PEA_G3_ADCSW 2
`define PEA_PIN_PWROFF 0
`define PEA_PIN_KEY 1
`define PEA_PIN_EXTRST 2
`define PEA_PIN_BUS 3
`define PEA_PIN_GPIO 4
`define PEA_WAKE_G1 8'h02
`define PEA_WAKE_G2 8'h60
`define PEA_WAKE_G3 8'h87
`define PEA_WAKE_G4 8'h7f
`define PEA_CLK_MHZ 40
`define PEA_KEY_TICK_US 1000
`define PEA_KEY_TICK_CYC (`PEA_KEY_TICK_US * `PEA_CLK_MHZ)

`endif

// file: design/pea_pkg.sv
// Types shared by the event aggregator modules.
`include "pea_map.svh"

package pea_pkg;
	typedef enum logic [1:0] {PEA_OFF, PEA_SLEEP, PEA_ACTIVE} pea_pwr_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] pending;
	} pea_grp_st_t;

	typedef struct packed {
		logic [`PEA_PIN_W-1:0] ff1;
		logic [`PEA_PIN_W-1:0] ff2;
		logic [`PEA_PIN_W-1:0] ff3;
		logic [`PEA_PIN_W-1:0] stable;
	} pea_sync_st_t;

	typedef struct packed {
		logic [3:0][7:0] mask;
		logic [7:0] rise4;
		logic [7:0] fall4;
		logic [2:0] ctrl;
		logic [7:0] keyDelay;
		logic [2:0] aux;
		logic [7:0] rdData;
		logic alertPin;
		logic lastValid;
		logic [1:0] lastIdx;
		logic [15:0] prescale;
		logic [7:0] heldTicks;
		logic heldFired;
		logic [`PEA_PIN_W-1:0] pinPrev;
		logic [5:0] lvlPrev;
	} pea_top_st_t;
endpackage

// file: design/pea_sync.sv
// Three-stage synchroniser for the pin inputs with agreement filter on the last two stages.
`include "pea_map.svh"
module pea_sync
	import pea_pkg::*;
(
	input wire logic sys_clk, // Device clock.
	input wire logic sys_rst, // Asynchronous reset, active high.
	input wire logic clkEn, // Freezes all state while low.
	input wire logic [`PEA_PIN_W-1:0] pinRaw, // Asynchronous pin levels.
	output logic [`PEA_PIN_W-1:0] pinStable // Filtered synchronous levels.
);
	// The key pin idles high, so its stages leave reset high and no false edge follows reset.
	localparam logic [`PEA_PIN_W-1:0] PIN_IDLE = `PEA_PIN_W'(1) << `PEA_PIN_KEY;
	pea_sync_st_t st;
	pea_sync_st_t next_st;

	always_comb begin
		next_st = st;
		next_st.ff1 = pinRaw;
		next_st.ff2 = st.ff1;
		next_st.ff3 = st.ff2;
		for (int i = 0; i < `PEA_PIN_W; i++) begin
			// A level only counts once two sampled stages agree, so one bad sample is ignored.
			if (st.ff2[i] == st.ff3[i]) begin
				next_st.stable[i] = st.ff3[i];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= {PIN_IDLE, PIN_IDLE, PIN_IDLE, PIN_IDLE};
		end else if (clkEn) begin
			st <= next_st;
		end
	end

	assign pinStable = st.stable;
endmodule

// file: design/pea_top.sv
// Event aggregator: four event groups, alert line, wake request and register port.
`include "pea_map.svh"
module pea_top
	import pea_pkg::*;
#(
	parameter int unsigned KEY_TICK_CYCLES = `PEA_KEY_TICK_CYC
) (
	input wire logic sys_clk, // Device clock, 40 MHz.
	input wire logic sys_rst, // Asynchronous reset, active high.
	input wire logic clkEn, // Freezes all state while low.
	input wire pea_pwr_t powerState, // Device power state.
	input wire logic powerOffRequestPin, // Power-off request pin, asynchronous.
	input wire logic powerKeyInput, // Power key pin, pressed when low, asynchronous.
	input wire logic extResetPin, // External reset pin, asynchronous.
	input wire logic busSupplyPin, // Bus supply wake comparator, asynchronous.
	input wire logic [6:0] gpioPin, // General purpose pins, asynchronous.
	input wire logic supplyMonitorLevel, // Supply above threshold.
	input wire logic dieOverheatLevel, // Die above overheat threshold.
	input wire logic shortLevel, // Any regulator output shorted.
	input wire logic firstSupplyLevel, // First supply detected.
	input wire logic watchdogExpiry, // Watchdog time-out expired.
	input wire logic fuseErrorLevel, // Fuse memory bit error seen.
	input wire logic adcManualDone, // Manual conversion result ready, pulse.
	input wire logic [1:0] adcPeriodicDone, // Periodic conversion finished, pulses.
	input wire logic [1:0] adcPeriodicAbove, // Periodic result above its threshold.
	input wire logic [`PEA_ADDR_W-1:0] regAddr, // Register address.
	input wire logic regWrEn, // Register write strobe.
	input wire logic [7:0] regWrData, // Register write data.
	input wire logic regRdEn, // Register read strobe.
	output logic [7:0] regRdData, // Read data, valid the cycle after the strobe.
	output logic alertPin, // Combined alert line toward the host.
	output logic wakeRequest // Power-on request toward the sequencer.
);
	// Idle levels of the synchronised pins; only the key pin rests high.
	localparam logic [`PEA_PIN_W-1:0] PIN_IDLE = `PEA_PIN_W'(1) << `PEA_PIN_KEY;

	// All registered state of this module lives in one struct; the groups and the synchroniser keep their own.
	pea_top_st_t st;
	pea_top_st_t next_st;
	// Pin levels before and after the synchroniser, and their edges.
	logic [`PEA_PIN_W-1:0] pinRaw;
	logic [`PEA_PIN_W-1:0] pinStable;
	logic [`PEA_PIN_W-1:0] pinRise;
	logic [`PEA_PIN_W-1:0] pinFall;
	// Internal levels arrive on this clock and need no synchroniser.
	logic [5:0] lvlNow;
	logic [5:0] lvlRise;
	logic [5:0] lvlFall;
	// Per-group event, clear, status, live-line and wake vectors.
	logic [3:0][7:0] rawEvt;
	logic [3:0][7:0] evt;
	logic [3:0][7:0] clr;
	logic [3:0][7:0] status;
	logic [3:0][7:0] lineState;
	logic [3:0][7:0] wakeCap;
	logic deviceOn;
	logic alertActive;
	logic keyTick;
	logic keyHeldEvt;
	logic keyPressMaskedWake;
	logic [1:0] adcHit;
	// Register port decode.
	logic isStatus;
	logic isMask;
	logic isLine;
	logic [1:0] grpIdx;
	logic clearOk;
	logic readClear;
	logic writeClear;
	logic [7:0] rdValue;

	function automatic logic inGroupRange(input logic [`PEA_ADDR_W-1:0] addr,
		input logic [`PEA_ADDR_W-1:0] base);
		inGroupRange = (addr >= base) && (addr < base + `PEA_ADDR_W'(4));
	endfunction

	function automatic logic [1:0] edgeOf(input logic now, input logic prev);
		edgeOf = {now & ~prev, ~now & prev};
	endfunction

	assign pinRaw = {gpioPin, busSupplyPin, extResetPin, powerKeyInput, powerOffRequestPin};

	pea_sync u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.pinRaw(pinRaw),
		.pinStable(pinStable)
	);

	// Index order: supply, overheat, first supply, watchdog, fuse, short.
	assign lvlNow = {shortLevel, fuseErrorLevel, watchdogExpiry, firstSupplyLevel,
		dieOverheatLevel, supplyMonitorLevel};

	always_comb begin
		for (int i = 0; i < `PEA_PIN_W; i++) begin
			{pinRise[i], pinFall[i]} = edgeOf(pinStable[i], st.pinPrev[i]);
		end
		for (int i = 0; i < 6; i++) begin
			{lvlRise[i], lvlFall[i]} = edgeOf(lvlNow[i], st.lvlPrev[i]);
		end
	end

	assign deviceOn = (powerState == PEA_ACTIVE) || (powerState == PEA_SLEEP);
	assign keyTick = (st.prescale == 16'(KEY_TICK_CYCLES - 1));
	// Fires once per press, on the tick at which the low time first exceeds the delay.
	assign keyHeldEvt = keyTick && !st.heldFired && !pinStable[`PEA_PIN_KEY] &&
		(st.heldTicks > st.keyDelay);

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			adcHit[i] = adcPeriodicDone[i] &&
				(adcPeriodicAbove[i] == st.aux[`PEA_AUX_ADC0_ABOVE + i]);
		end
	end

	// Raw source events before masking, one bit per documented position.
	always_comb begin
		rawEvt = '0;
		rawEvt[0][`PEA_G1_SUPPLY] = lvlRise[0] | lvlFall[0];
		rawEvt[0][`PEA_G1_HOT] = (lvlRise[1] | lvlFall[1]) & deviceOn;
		rawEvt[0][`PEA_G1_PWROFF] = pinRise[`PEA_PIN_PWROFF] | pinFall[`PEA_PIN_PWROFF];
		rawEvt[0][`PEA_G1_HELD] = keyHeldEvt;
		rawEvt[0][`PEA_G1_KEY] = pinFall[`PEA_PIN_KEY] & deviceOn;
		rawEvt[1][`PEA_G2_SHORT] = lvlRise[5];
		rawEvt[1][`PEA_G2_FIRST] = lvlRise[2] & st.aux[`PEA_AUX_FSSEL];
		rawEvt[1][`PEA_G2_EXTRST] = pinRise[`PEA_PIN_EXTRST];
		rawEvt[1][`PEA_G2_WDOG] = lvlRise[3];
		rawEvt[1][`PEA_G2_FUSE] = lvlRise[4];
		rawEvt[2][`PEA_G3_BUS] = pinRise[`PEA_PIN_BUS] | pinFall[`PEA_PIN_BUS];
		rawEvt[2][`PEA_G3_ADCSW] = adcManualDone;
		rawEvt[2][1:0] = adcHit;
		rawEvt[3][6:0] = (pinRise[`PEA_PIN_W-1:`PEA_PIN_GPIO] & st.rise4[6:0]) |
			(pinFall[`PEA_PIN_W-1:`PEA_PIN_GPIO] & st.fall4[6:0]);
	end

	// Masking blocks detection, so a masked source never reaches its status bit.
	always_comb begin
		for (int g = 0; g < 4; g++) begin
			evt[g] = rawEvt[g] & ~st.mask[g];
		end
	end

	assign wakeCap = {`PEA_WAKE_G4, `PEA_WAKE_G3, `PEA_WAKE_G2, `PEA_WAKE_G1};

	always_comb begin
		alertActive = 1'b0;
		wakeRequest = 1'b0;
		for (int g = 0; g < 4; g++) begin
			alertActive = alertActive | (|(status[g] & ~st.mask[g]));
			wakeRequest = wakeRequest | (|(status[g] & ~st.mask[g] & wakeCap[g]));
		end
		// The key press bit wakes the device even while its source is masked.
		wakeRequest = wakeRequest | status[0][`PEA_G1_KEY] | keyPressMaskedWake;
	end

	// A masked key press is not recorded but still has to wake the device.
	assign keyPressMaskedWake = pinFall[`PEA_PIN_KEY] & deviceOn &
		st.mask[0][`PEA_G1_KEY];

	// Live levels of each source except the manual conversion done pulse, read back through the line-state registers.
	always_comb begin
		lineState = '0;
		lineState[0][`PEA_G1_SUPPLY] = supplyMonitorLevel;
		lineState[0][`PEA_G1_HOT] = dieOverheatLevel;
		lineState[0][`PEA_G1_PWROFF] = pinStable[`PEA_PIN_PWROFF];
		lineState[0][`PEA_G1_HELD] = !pinStable[`PEA_PIN_KEY] && st.heldFired;
		lineState[0][`PEA_G1_KEY] = pinStable[`PEA_PIN_KEY];
		lineState[1][`PEA_G2_SHORT] = shortLevel;
		lineState[1][`PEA_G2_FIRST] = firstSupplyLevel;
		lineState[1][`PEA_G2_EXTRST] = pinStable[`PEA_PIN_EXTRST];
		lineState[1][`PEA_G2_WDOG] = watchdogExpiry;
		lineState[1][`PEA_G2_FUSE] = fuseErrorLevel;
		lineState[2][`PEA_G3_BUS] = pinStable[`PEA_PIN_BUS];
		lineState[2][1:0] = adcPeriodicAbove;
		lineState[3][6:0] = pinStable[`PEA_PIN_W-1:`PEA_PIN_GPIO];
	end

	assign isStatus = inGroupRange(regAddr, `PEA_OFF_STATUS);
	assign isMask = inGroupRange(regAddr, `PEA_OFF_MASK);
	assign isLine = inGroupRange(regAddr, `PEA_OFF_LINE);
	assign grpIdx = regAddr[1:0];
	// A second clear access to the same register is ignored until another one is touched.
	assign clearOk = !(st.lastValid && (st.lastIdx == grpIdx));
	assign readClear = regRdEn && isStatus && !st.ctrl[`PEA_CTRL_CLRWR] && clearOk;
	assign writeClear = regWrEn && isStatus && st.ctrl[`PEA_CTRL_CLRWR] && clearOk;

	// Only the addressed group sees a clear; the others hold.
	always_comb begin
		for (int g = 0; g < 4; g++) begin
			clr[g] = 8'h00;
			if (grpIdx == 2'(g)) begin
				if (readClear) begin
					clr[g] = 8'hff;
				end else if (writeClear) begin
					clr[g] = regWrData;
				end
			end
		end
	end

	for (genvar g = 0; g < 4; g++) begin : gen_group
		pea_group u_group (
			.sys_clk(sys_clk),
			.sys_rst(sys_rst),
			.clkEn(clkEn),
			.evt(evt[g]),
			.clr(clr[g]),
			.alertActive(alertActive),
			.keepRepeat(st.ctrl[`PEA_CTRL_KEEP]),
			.status(status[g])
		);
	end

	// Unmapped addresses read as all ones, as the host expects.
	always_comb begin
		rdValue = `PEA_UNMAPPED_RD;
		if (isStatus) begin
			rdValue = status[grpIdx];
		end else if (isMask) begin
			rdValue = st.mask[grpIdx];
		end else if (isLine) begin
			rdValue = lineState[grpIdx];
		end else if (regAddr == `PEA_OFF_RISE4) begin
			rdValue = st.rise4;
		end else if (regAddr == `PEA_OFF_FALL4) begin
			rdValue = st.fall4;
		end else if (regAddr == `PEA_OFF_CTRL) begin
			rdValue = {5'h00, st.ctrl};
		end else if (regAddr == `PEA_OFF_KEYDLY) begin
			rdValue = st.keyDelay;
		end else if (regAddr == `PEA_OFF_AUX) begin
			rdValue = {5'h00, st.aux};
		end
	end

	always_comb begin
		next_st = st;
		next_st.pinPrev = pinStable;
		next_st.lvlPrev = lvlNow;
		// Read data is captured once per read and then held until the next read.
		if (regRdEn) begin
			next_st.rdData = rdValue;
		end
		if (regWrEn) begin
			if (isMask) begin
				next_st.mask[grpIdx] = regWrData;
			end else if (regAddr == `PEA_OFF_RISE4) begin
				next_st.rise4 = {1'b0, regWrData[6:0]};
			end else if (regAddr == `PEA_OFF_FALL4) begin
				next_st.fall4 = {1'b0, regWrData[6:0]};
			end else if (regAddr == `PEA_OFF_CTRL) begin
				next_st.ctrl = regWrData[2:0];
			end else if (regAddr == `PEA_OFF_KEYDLY) begin
				next_st.keyDelay = regWrData;
			end else if (regAddr == `PEA_OFF_AUX) begin
				next_st.aux = regWrData[2:0];
			end
		end
		// Track the last cleared status register for the one-clear-per-visit rule.
		if (readClear || writeClear) begin
			next_st.lastValid = 1'b1;
			next_st.lastIdx = grpIdx;
		end else if ((regRdEn || regWrEn) && !(isStatus && (grpIdx == st.lastIdx))) begin
			// Any access to another register re-arms clearing of the last one.
			next_st.lastValid = 1'b0;
		end
		// Key timer: a free prescaler gives the delay unit, the tick count runs while low.
		next_st.prescale = keyTick ? 16'h0000 : st.prescale + 16'h0001;
		if (pinStable[`PEA_PIN_KEY]) begin
			next_st.heldTicks = 8'h00;
			next_st.heldFired = 1'b0;
		end else if (keyTick) begin
			if (st.heldTicks != 8'hff) begin
				next_st.heldTicks = st.heldTicks + 8'h01;
			end
			if (keyHeldEvt) begin
				next_st.heldFired = 1'b1;
			end
		end
		next_st.alertPin = alertActive ^ ~st.ctrl[`PEA_CTRL_POL];
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
			st.mask <= {4{`PEA_RST_MASK}};
			st.rise4 <= `PEA_RST_EDGE;
			st.fall4 <= `PEA_RST_EDGE;
			st.ctrl <= `PEA_RST_CTRL;
			st.keyDelay <= `PEA_RST_KEYDLY;
			st.aux <= `PEA_RST_AUX;
			st.alertPin <= 1'b1;
			st.pinPrev <= PIN_IDLE;
		end else if (clkEn) begin
			st <= next_st;
		end
	end

	assign regRdData = st.rdData;
	assign alertPin = st.alertPin;
endmodule

// file: design/pea_top_fix.sv
// (intentionally empty)

// file: testbench/pea_host_model.sv
// Host model that reads and clears the event registers over the register port.
`include "pea_map.svh"
module pea_host_model (
	input wire logic sys_clk, // Device clock.
	output logic [`PEA_ADDR_W-1:0] regAddr, // Register address.
	output logic regWrEn, // Write strobe.
	output logic [7:0] regWrData, // Write data.
	output logic regRdEn, // Read strobe.
	input wire logic [7:0] regRdData // Read data.
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		regRdEn = 1'b0;
	end
	// Strobes move only at falling edges so the device samples settled values.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge sys_clk);
		regWrEn = 1'b0;
		regWrData = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge sys_clk);
		regRdEn = 1'b0;
		d = regRdData;
	endtask
endmodule

// file: testbench/pea_top_properties.sv
// Concurrent checks on the ports of the event aggregator.
`include "pea_map.svh"
module pea_top_properties
	import pea_pkg::*;
(
	input wire logic sys_clk, // Device clock.
	input wire logic sys_rst, // Reset.
	input wire logic clkEn, // Clock enable.
	input wire pea_pwr_t powerState, // Power state.
	input wire logic powerKeyInput, // Power key pin.
	input wire logic busSupplyPin, // Bus supply pin.
	input wire logic shortLevel, // Short indication.
	input wire logic watchdogExpiry, // Watchdog expiry.
	input wire logic [`PEA_ADDR_W-1:0] regAddr, // Address.
	input wire logic regWrEn, // Write strobe.
	input wire logic [7:0] regWrData, // Write data.
	input wire logic regRdEn, // Read strobe.
	input wire logic [7:0] regRdData, // Read data.
	input wire logic alertPin, // Alert line.
	input wire logic wakeRequest // Wake request.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0][7:0] maskG;
	logic pol;
	logic [1:0] lastIdx;
	logic quiet;
	// Shadow copies of mask and polarity, since only the ports are visible here.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			maskG <= '0;
			pol <= 1'b0;
			lastIdx <= 2'h0;
		end else if (clkEn) begin
			lastIdx <= regAddr[1:0];
			if (regWrEn && regAddr[7:2] == 6'h01) begin
				maskG[regAddr[1:0]] <= regWrData;
			end
			if (regWrEn && regAddr == `PEA_OFF_CTRL) begin
				pol <= regWrData[`PEA_CTRL_POL];
			end
		end
	end
	assign quiet = clkEn && !regRdEn && !regWrEn;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence keyPress;
		powerKeyInput[*4] ##1
		(quiet && !powerKeyInput && powerState != PEA_OFF && !maskG[0][1])[*7];
	endsequence
	sequence busEdge;
		!busSupplyPin[*4] ##1 (quiet && busSupplyPin && !maskG[2][7])[*7];
	endsequence
	unmapped_read_a: assert property (
		clkEn && regRdEn && regAddr > `PEA_OFF_AUX |=> regRdData == `PEA_UNMAPPED_RD)
		else $error("unmapped read not all ones");
	rdata_hold_a: assert property (
		!(clkEn && regRdEn) |=> $stable(regRdData))
		else $error("read data moved without a read");
	mask_readback_a: assert property (
		clkEn && regRdEn && regAddr[7:2] == 6'h01 |=> regRdData == maskG[lastIdx])
		else $error("mask readback wrong");
	wake_alert_a: assert property (
		clkEn && wakeRequest && !regWrEn && !maskG[0][1] |=> alertPin == pol)
		else $error("wake without active alert");
	key_wake_a: assert property (
		keyPress |-> wakeRequest)
		else $error("key press gave no wake");
	bus_wake_a: assert property (
		busEdge |-> wakeRequest)
		else $error("bus supply edge gave no wake");
	wdog_alert_a: assert property (
		$rose(watchdogExpiry) && !maskG[1][2] ##0 quiet[*3] |-> alertPin == pol)
		else $error("watchdog event not on alert in two cycles");
	short_wake_a: assert property (
		$rose(shortLevel) && !maskG[1][6] ##0 quiet[*2] |-> wakeRequest)
		else $error("short event gave no wake");
endmodule
bind pea_top pea_top_properties props (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn),
	.powerState(powerState), .powerKeyInput(powerKeyInput), .busSupplyPin(busSupplyPin),
	.shortLevel(shortLevel), .watchdogExpiry(watchdogExpiry), .regAddr(regAddr),
	.regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
	.alertPin(alertPin), .wakeRequest(wakeRequest));

// file: testbench/pmic_event_aggregator_tb.sv
// Self-checking bench for the event aggregator.
`include "pea_map.svh"
module pmic_event_aggregator_tb;
	import pea_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] GRP [11] = '{0, 0, 1, 1, 1, 1, 2, 0, 1, 2, 0};
	localparam logic [7:0] BITS [11] = '{8'h40, 8'h20, 8'h40, 8'h20, 8'h04, 8'h02, 8'h04,
		8'h10, 8'h10, 8'h80, 8'h02};
	localparam logic [10:0] WAKE = 11'h64c;
	localparam logic [7:0] RA [10] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0c, 8'h0d, 8'h0e,
		8'h0f, 8'h10, 8'h20};
	localparam logic [7:0] RV [10] = '{0, 0, 0, 0, 0, 0, 0, 8'h08, 8'h01, 8'hff};
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clkEn = 1'b1;
	pea_pwr_t powerState = PEA_ACTIVE;
	logic [10:0] evt = '0;
	logic [6:0] gpioPin = '0;
	logic [1:0] adcDone = '0;
	logic [1:0] adcAbove = '0;
	logic [7:0] regAddr;
	logic regWrEn;
	logic [7:0] regWrData;
	logic regRdEn;
	logic [7:0] regRdData;
	logic [7:0] v;
	logic alertPin;
	logic wakeRequest;
	int nMismatch = 0;
	int totalChecks = 0;
	int cyc = 0;
	always #12.5 sys_clk = ~sys_clk;
	pea_top #(.KEY_TICK_CYCLES(4)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn),
		.powerState(powerState), .powerOffRequestPin(evt[7]), .powerKeyInput(~evt[10]),
		.extResetPin(evt[8]), .busSupplyPin(evt[9]), .gpioPin(gpioPin),
		.supplyMonitorLevel(evt[0]), .dieOverheatLevel(evt[1]), .shortLevel(evt[2]),
		.firstSupplyLevel(evt[3]), .watchdogExpiry(evt[4]), .fuseErrorLevel(evt[5]),
		.adcManualDone(evt[6]), .adcPeriodicDone(adcDone), .adcPeriodicAbove(adcAbove),
		.regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
		.regRdData(regRdData), .alertPin(alertPin), .wakeRequest(wakeRequest));
	pea_host_model host (.sys_clk(sys_clk), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		totalChecks++;
		if (got !== exp) begin
			nMismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, v);
		chk(v, e);
	endtask
	// A clearing access to the status register cleared last is ignored, so touch another first.
	task automatic rcs(input logic [7:0] a, input logic [7:0] e);
		host.rd(8'h04, v);
		rc(a, e);
	endtask
	task automatic tallyAndFinish();
		$display("checks %0d mismatches %0d", totalChecks, nMismatch);
		if (nMismatch == 0 && totalChecks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// The whole run needs under two thousand cycles, so this only catches a hang.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			nMismatch++;
			$display("[FAIL] %0t run did not finish", $time);
			tallyAndFinish();
		end
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		sys_rst = 1'b0;
		// Pins leave reset through the synchroniser, so flush anything that start-up left.
		for (int g = 0; g < 4; g++) begin
			host.rd(8'(g), v);
		end
		repeat (2) @(negedge sys_clk);
		chk({7'h0, alertPin}, 8'h01);
		foreach (RA[i]) begin
			rc(RA[i], RV[i]);
		end
		host.wr(8'h20, 8'h00);
		host.wr(8'h05, 8'h5a);
		rc(8'h05, 8'h5a);
		host.wr(8'h05, 8'h00);
		rc(8'h20, 8'hff);
		$display("test registers done");
		for (int i = 0; i < 11; i++) begin
			@(negedge sys_clk);
			evt[i] = 1'b1;
			if (i == 6) begin
				@(negedge sys_clk);
				evt[6] = 1'b0;
			end
			repeat (8) @(negedge sys_clk);
			chk({7'h0, wakeRequest}, {7'h0, WAKE[i]});
			chk({7'h0, alertPin}, 8'h00);
			rcs({6'h0, GRP[i]}, BITS[i]);
			repeat (2) @(negedge sys_clk);
			chk({7'h0, alertPin}, 8'h01);
		end
		repeat (40) @(negedge sys_clk);
		rcs(8'h00, 8'h04);
		repeat (40) @(negedge sys_clk);
		rc(8'h00, 8'h00);
		evt = '0;
		repeat (8) @(negedge sys_clk);
		rcs(8'h00, 8'h70);
		rc(8'h01, 8'h00);
		rc(8'h02, 8'h80);
		$display("test sources done");
		powerState = PEA_OFF;
		evt[1] = 1'b1;
		evt[9] = 1'b1;
		evt[10] = 1'b1;
		repeat (8) @(negedge sys_clk);
		evt = '0;
		repeat (8) @(negedge sys_clk);
		rc(8'h00, 8'h00);
		rc(8'h02, 8'h80);
		powerState = PEA_ACTIVE;
		$display("test off state done");
		host.wr(8'h0c, 8'h0f);
		host.wr(8'h0d, 8'h3c);
		gpioPin = 7'h7f;
		repeat (8) @(negedge sys_clk);
		rc(8'h03, 8'h0f);
		rc(8'h0b, 8'h7f);
		host.wr(8'h07, 8'h04);
		gpioPin = 7'h00;
		repeat (8) @(negedge sys_clk);
		rc(8'h03, 8'h38);
		host.wr(8'h07, 8'h00);
		$display("test pins done");
		adcDone = 2'b01;
		adcAbove = 2'b10;
		@(negedge sys_clk);
		adcDone = 2'b10;
		@(negedge sys_clk);
		adcDone = 2'b00;
		repeat (4) @(negedge sys_clk);
		rc(8'h02, 8'h01);
		host.wr(8'h10, 8'h05);
		@(negedge sys_clk);
		adcDone = 2'b11;
		@(negedge sys_clk);
		adcDone = 2'b00;
		repeat (4) @(negedge sys_clk);
		rc(8'h02, 8'h03);
		$display("test converter done");
		host.wr(8'h0e, 8'h06);
		gpioPin[0] = 1'b1;
		repeat (8) @(negedge sys_clk);
		gpioPin[0] = 1'b0;
		repeat (8) @(negedge sys_clk);
		gpioPin[0] = 1'b1;
		repeat (8) @(negedge sys_clk);
		rc(8'h03, 8'h01);
		host.wr(8'h03, 8'h01);
		rc(8'h03, 8'h01);
		host.rd(8'h00, v);
		host.wr(8'h03, 8'h01);
		rc(8'h03, 8'h00);
		$display("test clear methods done");
		// A write while the clock enable is low must not land.
		clkEn = 1'b0;
		host.wr(8'h06, 8'hff);
		clkEn = 1'b1;
		rc(8'h06, 8'h00);
		host.wr(8'h0e, 8'h01);
		repeat (2) @(negedge sys_clk);
		chk({7'h0, alertPin}, 8'h00);
		evt[2] = 1'b1;
		repeat (4) @(negedge sys_clk);
		chk({7'h0, wakeRequest}, 8'h01);
		chk({7'h0, alertPin}, 8'h01);
		rc(8'h01, 8'h40);
		$display("test polarity done");
		tallyAndFinish();
	end
endmodule
